// *** src/eight_bit_interval_timer.sv ***
// Purpose: eight independent 8-bit interval timers with prescaler,
//          match interrupts and four toggle outputs
// Assumes: mclk 50 MHz, nrst async active low, one-cycle strobes
// Notes:   read data valid the cycle after the read strobe
`timescale 1ns/1ns

// How it works
// - eight timers each own counter, compare, run bit and match interrupt
// - counter equal to compare raises match interrupt when unmasked
// - ticks of 8, 32, 128 and 2048 system clocks selectable
// - mode field 00 is interval mode; clock code 01 picks divide-by-8
// - run bit 0 stops and clears the counter; 1 starts it
// - toggle enable 1: match of the timer picked by source select inverts flop
// - one control write can clear the flop and arm inversion together
// - prescaler run bit starts prescaler; 0 stops and clears it; reset 0
// - match pulses detect, clears counter, requests interrupt
// - compare zero matches on counter overflow, 256 ticks
// - control 01 sets flop, 10 clears, 00 inverts
module eight_bit_interval_timer
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // interrupt
   output logic            irq,
   // toggle flop outputs, one per timer pair (0-1, 2-3, 4-5, 6-7), odd or even timer picked by source select
   output logic      [3:0] timer_output_pin
);

   typedef struct packed {
      logic [7:0]      timer_run_control;
      logic            prescaler_run;
      logic [3:0][7:0] pair_mode_select;
      logic [7:0][7:0] compare_value;
      logic [3:0]      toggle_enable;
      logic [3:0]      toggle_source_select;
      logic [3:0]      output_toggle_ff;
      logic [10:0]     prescale;
      logic [7:0]      status;
      logic [7:0]      mask;
      logic            irq;
      logic [7:0]      rdata;
   } core_s;

   core_s st;
   core_s next_st;

   logic [7:0] match_v;
   logic [7:0] tick_v;
   logic [7:0] count_v [8];
   logic       tick_div8;
   logic       tick_div32;
   logic       tick_div128;
   logic       tick_div2048;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic in_group(input logic [7:0] a, input logic [7:0] base);
      in_group = a[7:3] == base[7:3];
   endfunction

   function automatic logic [1:0] clk_code(input logic [7:0] mode, input int idx);
      if (idx % 2 == 1)
         clk_code = mode[itmr_pkg::CLK_ODD_LSB +: 2];
      else
         clk_code = mode[itmr_pkg::CLK_EVEN_LSB +: 2];
   endfunction

   // ------------------------------------------------------------
   // prescaler taps
   // ------------------------------------------------------------
   always_comb
   begin
      tick_div8    = st.prescaler_run
                     && (st.prescale[2:0] == itmr_pkg::TAP_DIV8[2:0]);
      tick_div32   = st.prescaler_run
                     && (st.prescale[4:0] == itmr_pkg::TAP_DIV32[4:0]);
      tick_div128  = st.prescaler_run
                     && (st.prescale[6:0] == itmr_pkg::TAP_DIV128[6:0]);
      tick_div2048 = st.prescaler_run
                     && (st.prescale == itmr_pkg::TAP_DIV2048);
   end

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < itmr_pkg::NUM_TIMERS; i++)
   begin : g_ch
      timer_ch_if ch ();
      logic [7:0] mode;
      assign mode = st.pair_mode_select[i / 2];
      always_comb
      begin
         unique case (clk_code(mode, i))
            itmr_pkg::CLK_DIV8:    tick_v[i] = tick_div8;
            itmr_pkg::CLK_DIV32:   tick_v[i] = tick_div32;
            itmr_pkg::CLK_DIV128:  tick_v[i] = tick_div128;
            itmr_pkg::CLK_DIV2048: tick_v[i] = tick_div2048;
         endcase
      end
      // counting only in interval mode
      assign ch.tick = tick_v[i]
                       && (mode[itmr_pkg::MODE_LSB +: 2] == itmr_pkg::MODE_INTERVAL);
      assign ch.run  = st.timer_run_control[i];
      assign ch.cmp  = st.compare_value[i];
      assign match_v[i] = ch.match;
      assign count_v[i] = ch.count;
      timer_channel u_ch
      (
         .mclk (mclk),
         .nrst (nrst),
         .ch   (ch.chan)
      );
   end

   // ------------------------------------------------------------
   // register and event logic
   // ------------------------------------------------------------
   always_comb
   begin
      logic [7:0] clr;
      logic [3:0] nib;
      logic       src;
      clr = 8'h00;
      nib = 4'h0;
      src = 1'b0;
      next_st = st;

      if (st.prescaler_run)
         next_st.prescale = st.prescale + 11'h001;
      else
         next_st.prescale = 11'h000;

      if (rd && addr == itmr_pkg::ADDR_STATUS)
         clr = 8'hFF;

      for (int k = 0; k < itmr_pkg::NUM_PAIRS; k++)
      begin
         src = st.toggle_source_select[k] ? match_v[2 * k + 1] : match_v[2 * k];
         nib = (k < 2) ? wdata[(k % 2) * itmr_pkg::FF_NIB +: 4]
                       : wdata[(k % 2) * itmr_pkg::FF_NIB +: 4];
         if (wr && addr == ((k < 2) ? itmr_pkg::ADDR_FFC_LO : itmr_pkg::ADDR_FFC_HI))
         begin
            next_st.toggle_enable[k]        = nib[itmr_pkg::FF_IE_BIT];
            next_st.toggle_source_select[k] = nib[itmr_pkg::FF_IS_BIT];
            unique case (nib[1:0])
               itmr_pkg::FF_SET:    next_st.output_toggle_ff[k] = 1'b1;
               itmr_pkg::FF_CLEAR:  next_st.output_toggle_ff[k] = 1'b0;
               itmr_pkg::FF_INVERT: next_st.output_toggle_ff[k] = ~st.output_toggle_ff[k];
               default:             next_st.output_toggle_ff[k] = st.output_toggle_ff[k];
            endcase
         end
         else if (st.toggle_enable[k] && src)
         begin
            next_st.output_toggle_ff[k] = ~st.output_toggle_ff[k];
         end
      end

      if (wr)
      begin
         if (addr == itmr_pkg::ADDR_RUN)
            next_st.timer_run_control = wdata;
         if (addr == itmr_pkg::ADDR_PRE_RUN)
            next_st.prescaler_run = wdata[itmr_pkg::PRE_RUN_BIT];
         if (in_group(addr, itmr_pkg::ADDR_MODE_BASE) && addr[2])
            next_st.pair_mode_select[addr[1:0]] = wdata;
         if (in_group(addr, itmr_pkg::ADDR_CMP_BASE))
            next_st.compare_value[addr[2:0]] = wdata;
         if (addr == itmr_pkg::ADDR_MASK)
            next_st.mask = wdata;
      end

      // set wins over read clear
      next_st.status = (st.status & ~clr) | match_v;
      next_st.irq = |(next_st.status & next_st.mask);

      next_st.rdata = 8'h00;
      if (rd)
      begin
         if (addr == itmr_pkg::ADDR_RUN)
            next_st.rdata = st.timer_run_control;
         else if (addr == itmr_pkg::ADDR_PRE_RUN)
            next_st.rdata = {st.prescaler_run, 7'h00};
         else if (in_group(addr, itmr_pkg::ADDR_MODE_BASE) && addr[2])
            next_st.rdata = st.pair_mode_select[addr[1:0]];
         else if (in_group(addr, itmr_pkg::ADDR_CMP_BASE))
            next_st.rdata = st.compare_value[addr[2:0]];
         else if (addr == itmr_pkg::ADDR_FFC_LO)
            next_st.rdata = {st.toggle_enable[1], st.toggle_source_select[1], 2'h3,
                             st.toggle_enable[0], st.toggle_source_select[0], 2'h3};
         else if (addr == itmr_pkg::ADDR_FFC_HI)
            next_st.rdata = {st.toggle_enable[3], st.toggle_source_select[3], 2'h3,
                             st.toggle_enable[2], st.toggle_source_select[2], 2'h3};
         else if (addr == itmr_pkg::ADDR_STATUS)
            next_st.rdata = st.status;
         else if (addr == itmr_pkg::ADDR_MASK)
            next_st.rdata = st.mask;
         else if (addr == itmr_pkg::ADDR_TFF)
            next_st.rdata = {4'h0, st.output_toggle_ff};
         else if (in_group(addr, itmr_pkg::ADDR_CNT_BASE))
            next_st.rdata = count_v[addr[2:0]];
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   assign rdata            = st.rdata;
   assign irq              = st.irq;
   assign timer_output_pin = st.output_toggle_ff;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_irq_masked: assert property (
      irq == |(st.status & st.mask))
      else $error("interrupt output disagrees with status and mask");
   a_pre_stopped: assert property (
      !st.prescaler_run |=> st.prescale == 11'h000 && !tick_div8)
      else $error("prescaler not cleared while stopped");
   a_div8_spacing: assert property (
      tick_div8 && st.prescaler_run ##1 st.prescaler_run [*8] |-> tick_div8)
      else $error("divide-by-8 tick spacing wrong");
   a_status_set: assert property (
      match_v[1] |=> st.status[1])
      else $error("match did not set status");
   a_toggle_match: assert property (
      st.toggle_enable[0] && st.toggle_source_select[0] && match_v[1]
      && !(wr && addr == itmr_pkg::ADDR_FFC_LO)
      |=> timer_output_pin[0] != $past(timer_output_pin[0]))
      else $error("toggle flop missed timer match");
   a_ffc_clear: assert property (
      wr && addr == itmr_pkg::ADDR_FFC_LO && wdata[1:0] == itmr_pkg::FF_CLEAR
      |=> !timer_output_pin[0] && st.toggle_enable[0] == $past(wdata[3]))
      else $error("flop clear and arm not taken together");

   // ------------------------------------------------------------
   // register and tap checks
   // ------------------------------------------------------------
   a_run_write: assert property (
      wr && addr == itmr_pkg::ADDR_RUN |=> st.timer_run_control == $past(wdata))
      else $error("run bits not taken from write");
   a_pre_start: assert property (
      wr && addr == itmr_pkg::ADDR_PRE_RUN
      |=> st.prescaler_run == $past(wdata[itmr_pkg::PRE_RUN_BIT]))
      else $error("prescaler run bit not taken from write");
   a_mode_write: assert property (
      wr && in_group(addr, itmr_pkg::ADDR_MODE_BASE) && addr[2]
      |=> st.pair_mode_select[$past(addr[1:0])] == $past(wdata))
      else $error("mode write missed its pair");
   a_cmp_write: assert property (
      wr && in_group(addr, itmr_pkg::ADDR_CMP_BASE)
      |=> st.compare_value[$past(addr[2:0])] == $past(wdata))
      else $error("compare write missed its timer");
   a_mask_write: assert property (
      wr && addr == itmr_pkg::ADDR_MASK |=> st.mask == $past(wdata))
      else $error("mask not taken from write");
   a_status_clear: assert property (
      rd && addr == itmr_pkg::ADDR_STATUS && match_v == 8'h00 |=> st.status == 8'h00)
      else $error("status not cleared by read");
   a_status_sticky: assert property (
      !(rd && addr == itmr_pkg::ADDR_STATUS)
      |=> (st.status & $past(st.status)) == $past(st.status))
      else $error("status bit lost without a read");
   a_rdata_status: assert property (
      rd && addr == itmr_pkg::ADDR_STATUS |=> rdata == $past(st.status))
      else $error("status read data wrong");
   a_cnt_read: assert property (
      rd && in_group(addr, itmr_pkg::ADDR_CNT_BASE) |=> rdata == $past(count_v[addr[2:0]]))
      else $error("counter read data wrong");
   a_ffc_set: assert property (
      wr && addr == itmr_pkg::ADDR_FFC_LO && wdata[1:0] == itmr_pkg::FF_SET
      |=> timer_output_pin[0])
      else $error("flop set by write failed");
   a_ffc_invert: assert property (
      wr && addr == itmr_pkg::ADDR_FFC_LO && wdata[1:0] == itmr_pkg::FF_INVERT
      |=> timer_output_pin[0] != $past(timer_output_pin[0]))
      else $error("flop invert by write failed");
   a_tap_nested: assert property (
      tick_div2048 |-> tick_div8 && tick_div32 && tick_div128)
      else $error("slow tick not aligned with faster ticks");
   a_tick_needs_pre: assert property (
      !st.prescaler_run
      |-> !tick_div8 && !tick_div32 && !tick_div128 && !tick_div2048)
      else $error("tick while prescaler stopped");
   a_mode_freeze: assert property (
      st.pair_mode_select[0][itmr_pkg::MODE_LSB +: 2] != itmr_pkg::MODE_INTERVAL
      && st.timer_run_control[1] |=> $stable(count_v[1]))
      else $error("counter moved outside interval mode");
endmodule

// *** src/itmr_pkg.sv ***
// Purpose: shared constants for the eight-channel interval timer
// Assumes: 8-bit register port, one system clock
// Notes:   address map, field positions and clock-source codes
package itmr_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int NUM_TIMERS = 8;
   localparam int NUM_PAIRS  = 4;
   localparam int CNT_W      = 8;
   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 8;
   localparam int PRE_W      = 11;

   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_RUN       = 8'h00;
   localparam logic [7:0] ADDR_PRE_RUN   = 8'h01;
   localparam logic [7:0] ADDR_MODE_BASE = 8'h04;
   localparam logic [7:0] ADDR_CMP_BASE  = 8'h08;
   localparam logic [7:0] ADDR_FFC_LO    = 8'h10;
   localparam logic [7:0] ADDR_FFC_HI    = 8'h11;
   localparam logic [7:0] ADDR_STATUS    = 8'h12;
   localparam logic [7:0] ADDR_MASK      = 8'h13;
   localparam logic [7:0] ADDR_TFF       = 8'h14;
   localparam logic [7:0] ADDR_CNT_BASE  = 8'h18;

   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   localparam int         PRE_RUN_BIT   = 7;
   localparam int         MODE_LSB      = 6;
   localparam int         CLK_EVEN_LSB  = 0;
   localparam int         CLK_ODD_LSB   = 2;
   localparam logic [1:0] MODE_INTERVAL = 2'h0;
   localparam logic [1:0] CLK_DIV2048   = 2'h0;
   localparam logic [1:0] CLK_DIV8      = 2'h1;
   localparam logic [1:0] CLK_DIV32     = 2'h2;
   localparam logic [1:0] CLK_DIV128    = 2'h3;
   localparam int         FF_IE_BIT     = 3;
   localparam int         FF_IS_BIT     = 2;
   localparam int         FF_NIB        = 4;
   localparam logic [1:0] FF_INVERT     = 2'h0;
   localparam logic [1:0] FF_SET        = 2'h1;
   localparam logic [1:0] FF_CLEAR      = 2'h2;

   // ------------------------------------------------------------
   // prescaler taps: tick when low bits are all ones
   // ------------------------------------------------------------
   localparam logic [10:0] TAP_DIV8    = 11'h007;
   localparam logic [10:0] TAP_DIV32   = 11'h01F;
   localparam logic [10:0] TAP_DIV128  = 11'h07F;
   localparam logic [10:0] TAP_DIV2048 = 11'h7FF;

endpackage

// *** src/timer_ch_if.sv ***
// Purpose: link between timer core and one counter channel
// Assumes: same clock on both sides
// Notes:   tick is a one-cycle enable
`timescale 1ns/1ns
interface timer_ch_if;
   logic       tick;
   logic       run;
   logic [7:0] cmp;
   logic [7:0] count;
   logic       match;
   modport ctrl (output tick, output run, output cmp, input count, input match);
   modport chan (input tick, input run, input cmp, output count, output match);
endinterface

// *** src/timer_channel.sv ***
// Purpose: one 8-bit up-counter with compare and match detect
// Assumes: tick already gated by prescaler run and mode
// Notes:   match is a one-cycle pulse, counter clears on it
`timescale 1ns/1ns
module timer_channel
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // channel link
   timer_ch_if.chan  ch
);

   typedef struct packed {
      logic [7:0] count;
      logic       match;
   } chan_s;

   chan_s st;
   chan_s next_st;
   logic [7:0] inc;

   always_comb
   begin
      next_st = st;
      next_st.match = 1'b0;
      inc = st.count + 8'h01;
      if (!ch.run)
      begin
         next_st.count = 8'h00;
      end
      else if (ch.tick)
      begin
         // compare 0 hits on wrap to zero: 256 ticks
         if (inc == ch.cmp)
         begin
            next_st.match = 1'b1;
            next_st.count = 8'h00;
         end
         else
         begin
            next_st.count = inc;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else
         st <= next_st;
   end

   assign ch.count = st.count;
   assign ch.match = st.match;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_match_clears: assert property (@(posedge mclk) disable iff (!nrst)
      st.match |-> st.count == 8'h00)
      else $error("counter not zero after match");
   a_stop_clears: assert property (@(posedge mclk) disable iff (!nrst)
      !ch.run |=> st.count == 8'h00 && !st.match)
      else $error("stopped counter not cleared");
   a_match_cause: assert property (@(posedge mclk) disable iff (!nrst)
      ch.run && ch.tick && (8'(st.count + 8'h01) == ch.cmp) |=> st.match)
      else $error("missed compare match");
   a_count_step: assert property (@(posedge mclk) disable iff (!nrst)
      ch.run && ch.tick && (8'(st.count + 8'h01) != ch.cmp)
      |=> st.count == 8'($past(st.count) + 8'h01) && !st.match)
      else $error("counter did not step by one");
   a_count_hold: assert property (@(posedge mclk) disable iff (!nrst)
      ch.run && !ch.tick |=> $stable(st.count) && !st.match)
      else $error("counter moved without tick");
endmodule

// *** testbench/tb_eight_bit_interval_timer.sv ***
// Purpose: self-checking bench for the eight-channel interval timer
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes:   periods measured on the timer 1 toggle output in mclk cycles
`timescale 1ns/1ns
module tb_eight_bit_interval_timer;
   logic       mclk;
   logic       nrst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       irq;
   logic [3:0] timer_output_pin;
   int         err_count;
   int         num_checks;
   logic [7:0] v;

   eight_bit_interval_timer uut
   (
      .mclk             (mclk),
      .nrst             (nrst),
      .addr             (addr),
      .wdata            (wdata),
      .wr               (wr),
      .rd               (rd),
      .rdata            (rdata),
      .irq              (irq),
      .timer_output_pin (timer_output_pin)
   );

   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
         err_count++;
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      @(posedge mclk);
      d = rdata;
   endtask

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // cycles between two toggles of the timer 1 output
   task automatic toggle_period(input int exp, input string what);
      logic p;
      int   n;
      n = 0;
      @(posedge mclk);
      p = timer_output_pin[0];
      while (timer_output_pin[0] === p && n < 5000)
      begin
         @(posedge mclk);
         n++;
      end
      p = timer_output_pin[0];
      n = 0;
      @(posedge mclk);
      while (timer_output_pin[0] === p && n < 5000)
      begin
         @(posedge mclk);
         n++;
      end
      chk(8'(n + 1 == exp), 8'h01, what);
      if (n >= 5000)
         close_out();
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd_reg(8'h00, v); chk(v, 8'h00, "run after reset");
      rd_reg(8'h01, v); chk(v, 8'h00, "prescaler after reset");
      rd_reg(8'h12, v); chk(v, 8'h00, "status after reset");
      rd_reg(8'h14, v); chk(v, 8'h00, "flops after reset");
      rd_reg(8'h3F, v); chk(v, 8'h00, "unmapped read");
      chk({7'h00, irq}, 8'h00, "irq after reset");
      $display("test reset done");
   endtask

   task automatic t_soft_flop;
      wr_reg(8'h10, 8'h31); rd_reg(8'h14, v); chk(v, 8'h01, "flop set");
      chk({4'h0, timer_output_pin}, 8'h01, "pin after set");
      wr_reg(8'h10, 8'h30); rd_reg(8'h14, v); chk(v, 8'h00, "flop invert");
      wr_reg(8'h10, 8'h30); rd_reg(8'h14, v); chk(v, 8'h01, "flop invert back");
      wr_reg(8'h10, 8'h3E); rd_reg(8'h14, v); chk(v, 8'h00, "clear and arm");
      rd_reg(8'h10, v); chk(v, 8'h3F, "control readback");
      $display("test soft flop done");
   endtask

   task automatic t_square_wave;
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h04, 8'h04);
      wr_reg(8'h09, 8'h03);
      wr_reg(8'h10, 8'h3E);
      wr_reg(8'h01, 8'h80);
      wr_reg(8'h00, 8'h02);
      toggle_period(24, "div8 compare 3");
      toggle_period(24, "div8 compare 3 again");
      $display("test square wave done");
   endtask

   task automatic t_clock_codes;
      logic [7:0] code [3];
      int         per  [3];
      code = '{8'h08, 8'h0C, 8'h00};
      per  = '{32, 128, 2048};
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(8'h00, 8'h00);
         wr_reg(8'h04, code[i]);
         wr_reg(8'h09, 8'h01);
         wr_reg(8'h00, 8'h02);
         toggle_period(per[i], "clock code period");
      end
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h04, 8'h04);
      wr_reg(8'h09, 8'h00);
      wr_reg(8'h00, 8'h02);
      toggle_period(2048, "compare zero period");
      $display("test clock codes done");
   endtask

   task automatic t_stop_clear;
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h09, 8'hF0);
      wr_reg(8'h00, 8'h02);
      wait_cycles(100);
      rd_reg(8'h19, v);
      chk(8'(v != 8'h00), 8'h01, "counter advancing");
      wr_reg(8'h00, 8'h00);
      rd_reg(8'h19, v); chk(v, 8'h00, "stop clears counter");
      wr_reg(8'h04, 8'h44);
      wr_reg(8'h00, 8'h02);
      wait_cycles(50);
      rd_reg(8'h19, v); chk(v, 8'h00, "other mode freezes count");
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h04, 8'h04);
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h00, 8'h02);
      wait_cycles(50);
      rd_reg(8'h19, v); chk(v, 8'h00, "prescaler stopped holds count");
      wr_reg(8'h00, 8'h00);
      $display("test stop clear done");
   endtask

   task automatic t_irq;
      int n;
      wr_reg(8'h13, 8'h00);
      wr_reg(8'h09, 8'h02);
      rd_reg(8'h12, v);
      wr_reg(8'h01, 8'h80);
      wr_reg(8'h00, 8'h02);
      wait_cycles(60);
      chk({7'h00, irq}, 8'h00, "masked irq stays low");
      wr_reg(8'h00, 8'h00);
      rd_reg(8'h12, v); chk(v, 8'h02, "status timer 1");
      rd_reg(8'h12, v); chk(v, 8'h00, "status cleared by read");
      wr_reg(8'h13, 8'h02);
      wr_reg(8'h00, 8'h02);
      n = 0;
      while (irq !== 1'b1 && n < 100)
      begin
         @(posedge mclk);
         n++;
      end
      chk({7'h00, irq}, 8'h01, "unmasked irq rises");
      wr_reg(8'h00, 8'h00);
      rd_reg(8'h12, v); chk(v, 8'h02, "status before clear");
      @(posedge mclk);
      chk({7'h00, irq}, 8'h00, "irq drops after read");
      $display("test irq done");
   endtask

   task automatic t_independent;
      wr_reg(8'h04, 8'h05);
      wr_reg(8'h08, 8'h02);
      wr_reg(8'h09, 8'h02);
      rd_reg(8'h12, v);
      wr_reg(8'h00, 8'h01);
      wait_cycles(60);
      wr_reg(8'h00, 8'h00);
      rd_reg(8'h12, v); chk(v, 8'h01, "only timer 0 matched");
      rd_reg(8'h08, v); chk(v, 8'h02, "compare 0 readback");
      $display("test independent done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      err_count  = 0;
      num_checks = 0;
      nrst  = 1'b0;
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      t_reset();
      t_soft_flop();
      t_square_wave();
      t_clock_codes();
      t_stop_clear();
      t_irq();
      t_independent();
      close_out();
   end
endmodule
